// >>> common/swen_consts.svh
// Register map, field positions, reset values for the socket window enable block.
// Assumes a 32-bit AXI4-Lite register bus; each register takes one aligned word.
`ifndef SWEN_CONSTS_SVH
`define SWEN_CONSTS_SVH

// ==========================================================
// Register indexes and byte addresses
`define SWEN_IDX_WIN_ENABLE    8'h06
`define SWEN_IDX_IO_WIN_CTRL   8'h07
`define SWEN_ADDR_WIN_ENABLE   (4 * `SWEN_IDX_WIN_ENABLE)
`define SWEN_ADDR_IO_WIN_CTRL  (4 * `SWEN_IDX_IO_WIN_CTRL)
`define SWEN_ADDR_W            8

// ==========================================================
// Reset values
`define SWEN_RST_WIN_ENABLE    8'h00
`define SWEN_RST_IO_WIN_CTRL   8'h00

// ==========================================================
// Window enable fields
`define SWEN_EN_MEM_LSB        0
`define SWEN_EN_MEM_MSB        4
`define SWEN_EN_COMPAT         5
`define SWEN_EN_IO0            6
`define SWEN_EN_IO1            7
// Writable bits of the enable register; bit 5 reads zero
`define SWEN_EN_WMASK          8'hDF

// ==========================================================
// I/O window control fields
`define SWEN_CTL_SIZE0         0
`define SWEN_CTL_AUTO0         1
`define SWEN_CTL_TSEL0         3
`define SWEN_CTL_SIZE1         4
`define SWEN_CTL_AUTO1         5
`define SWEN_CTL_TSEL1         7

// ==========================================================
// AXI responses
`define SWEN_RESP_OKAY         2'h0
`define SWEN_RESP_SLVERR       2'h2

`endif

// >>> common/swen_pkg.sv
// Types shared by the socket window enable block.
// Assumes nothing beyond a SystemVerilog compiler.
package swen_pkg;

  // ==========================================================
  // Card access sequencer states, one-hot
  typedef enum logic [1:0] {
    SWEN_ST_IDLE = 2'b01,
    SWEN_ST_BUSY = 2'b10
  } swen_state_t;

  typedef logic [7:0] swen_reg_t;

endpackage : swen_pkg

// >>> common/swen_if.sv
// Carrier between the register/sequencer top and the window decoder.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface swen_if;
  logic [4:0] mem_en;
  logic [1:0] io_en;
  logic [7:0] io_ctrl;
  logic       acc_is_io;
  logic [4:0] mem_hit;
  logic [1:0] io_hit;
  logic       ind16;
  logic       claim;
  logic [2:0] win_id;
  logic       width16;
  logic       timer_set;

  modport ctrl (
    output mem_en, io_en, io_ctrl, acc_is_io, mem_hit, io_hit, ind16,
    input  claim, win_id, width16, timer_set
  );
  modport dec (
    input  mem_en, io_en, io_ctrl, acc_is_io, mem_hit, io_hit, ind16,
    output claim, win_id, width16, timer_set
  );
endinterface : swen_if

// >>> hw/swen_window_decode.sv
// Window decoder: picks the enabled window an access hits and its card path.
// Assumes range comparison is done outside; hits arrive one bit per window.
`timescale 1ns/1ps
`include "swen_consts.svh"
module swen_window_decode
  import swen_pkg::*;
(
  // Decoder side of the carrier
  swen_if.dec d
);

  // Fixed size unless auto sizing, then follow the card
  function automatic logic io_width16(input logic size, input logic auto_sz, input logic ind);
    io_width16 = auto_sz ? ind : size;
  endfunction : io_width16

  logic [4:0] mem_live;
  logic [1:0] io_live;

  always_comb begin
    // Disabled windows never hit
    mem_live    = d.mem_hit & d.mem_en;
    io_live     = d.io_hit & d.io_en;
    d.claim     = 1'b0;
    d.win_id    = 3'h0;
    d.width16   = 1'b0;
    d.timer_set = 1'b0;
    if (d.acc_is_io) begin
      // Lowest window wins if ranges overlap
      if (io_live[0]) begin
        d.claim     = 1'b1;
        d.win_id    = 3'h0;
        d.width16   = io_width16(d.io_ctrl[`SWEN_CTL_SIZE0], d.io_ctrl[`SWEN_CTL_AUTO0], d.ind16);
        d.timer_set = d.io_ctrl[`SWEN_CTL_TSEL0];
      end else if (io_live[1]) begin
        d.claim     = 1'b1;
        d.win_id    = 3'h1;
        d.width16   = io_width16(d.io_ctrl[`SWEN_CTL_SIZE1], d.io_ctrl[`SWEN_CTL_AUTO1], d.ind16);
        d.timer_set = d.io_ctrl[`SWEN_CTL_TSEL1];
      end
    end else begin
      for (int i = 4; i >= 0; i--) begin
        if (mem_live[i]) begin
          d.claim  = 1'b1;
          d.win_id = 3'(i);
        end
      end
    end
  end

endmodule : swen_window_decode

// >>> hw/swen_top.sv
// Socket window enable and I/O window control registers with card access gating.
// Assumes one 100 MHz clock, window range hits computed by an outside comparator,
// and an AXI4-Lite master on the register port.
`timescale 1ns/1ps
`include "swen_consts.svh"
module swen_top
  import swen_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Host access request
  input  wire logic        acc_valid,
  input  wire logic        acc_is_io,
  input  wire logic [4:0]  acc_mem_hit,
  input  wire logic [1:0]  acc_io_hit,
  output logic             acc_ready,
  output logic             acc_claim,
  // Card side
  input  wire logic        card_io_width_indicator_n,
  input  wire logic        card_done,
  output logic             card_start,
  output logic             card_busy,
  output logic [2:0]       card_win_id,
  output logic             card_is_io,
  output logic             card_width16,
  output logic             card_timer_set
);

  // ==========================================================
  // Registers
  swen_reg_t win_enable_ff;
  swen_reg_t nxt_win_enable;
  swen_reg_t io_ctrl_ff;
  swen_reg_t nxt_io_ctrl;

  // ==========================================================
  // AXI4-Lite slave state
  logic                  aw_held_ff;
  logic                  nxt_aw_held;
  logic [`SWEN_ADDR_W-1:0] aw_addr_ff;
  logic [`SWEN_ADDR_W-1:0] nxt_aw_addr;
  logic                  w_held_ff;
  logic                  nxt_w_held;
  logic [7:0]            w_data_ff;
  logic [7:0]            nxt_w_data;
  logic                  w_strb0_ff;
  logic                  nxt_w_strb0;
  logic                  bvalid_ff;
  logic                  nxt_bvalid;
  logic [1:0]            bresp_ff;
  logic [1:0]            nxt_bresp;
  logic                  rvalid_ff;
  logic                  nxt_rvalid;
  logic [31:0]           rdata_ff;
  logic [31:0]           nxt_rdata;
  logic [1:0]            rresp_ff;
  logic [1:0]            nxt_rresp;
  logic                  do_write;

  assign s_axi_awready = ~aw_held_ff;
  assign s_axi_wready  = ~w_held_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // Write commits once address and data are both held and no response pends
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;

  always_comb begin
    nxt_aw_held    = aw_held_ff;
    nxt_aw_addr    = aw_addr_ff;
    nxt_w_held     = w_held_ff;
    nxt_w_data     = w_data_ff;
    nxt_w_strb0    = w_strb0_ff;
    nxt_bvalid     = bvalid_ff;
    nxt_bresp      = bresp_ff;
    nxt_win_enable = win_enable_ff;
    nxt_io_ctrl    = io_ctrl_ff;
    if (s_axi_awvalid && !aw_held_ff) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = s_axi_awaddr[`SWEN_ADDR_W-1:0];
    end
    if (s_axi_wvalid && !w_held_ff) begin
      nxt_w_held  = 1'b1;
      nxt_w_data  = s_axi_wdata[7:0];
      nxt_w_strb0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = `SWEN_RESP_OKAY;
      case (aw_addr_ff)
        `SWEN_ADDR_W'(`SWEN_ADDR_WIN_ENABLE): begin
          // Compatibility bit stays zero
          if (w_strb0_ff) begin
            nxt_win_enable = w_data_ff & `SWEN_EN_WMASK;
          end
        end
        `SWEN_ADDR_W'(`SWEN_ADDR_IO_WIN_CTRL): begin
          if (w_strb0_ff) begin
            nxt_io_ctrl = w_data_ff;
          end
        end
        default: begin
          nxt_bresp = `SWEN_RESP_SLVERR;
        end
      endcase
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // Upper address bits beyond the map alias onto it; only the low byte decodes
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = `SWEN_RESP_OKAY;
      case (s_axi_araddr[`SWEN_ADDR_W-1:0])
        `SWEN_ADDR_W'(`SWEN_ADDR_WIN_ENABLE): begin
          nxt_rdata = {24'h000000, win_enable_ff};
        end
        `SWEN_ADDR_W'(`SWEN_ADDR_IO_WIN_CTRL): begin
          nxt_rdata = {24'h000000, io_ctrl_ff};
        end
        default: begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = `SWEN_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff    <= 1'b0;
      aw_addr_ff    <= '0;
      w_held_ff     <= 1'b0;
      w_data_ff     <= 8'h00;
      w_strb0_ff    <= 1'b0;
      bvalid_ff     <= 1'b0;
      bresp_ff      <= `SWEN_RESP_OKAY;
      rvalid_ff     <= 1'b0;
      rdata_ff      <= 32'h00000000;
      rresp_ff      <= `SWEN_RESP_OKAY;
      win_enable_ff <= `SWEN_RST_WIN_ENABLE;
      io_ctrl_ff    <= `SWEN_RST_IO_WIN_CTRL;
    end else begin
      aw_held_ff    <= nxt_aw_held;
      aw_addr_ff    <= nxt_aw_addr;
      w_held_ff     <= nxt_w_held;
      w_data_ff     <= nxt_w_data;
      w_strb0_ff    <= nxt_w_strb0;
      bvalid_ff     <= nxt_bvalid;
      bresp_ff      <= nxt_bresp;
      rvalid_ff     <= nxt_rvalid;
      rdata_ff      <= nxt_rdata;
      rresp_ff      <= nxt_rresp;
      win_enable_ff <= nxt_win_enable;
      io_ctrl_ff    <= nxt_io_ctrl;
    end
  end

  // ==========================================================
  // Card width indication synchroniser
  logic ind_meta_ff;
  logic nxt_ind_meta;
  logic ind_sync_ff;
  logic nxt_ind_sync;

  always_comb begin
    nxt_ind_meta = card_io_width_indicator_n;
    nxt_ind_sync = ind_meta_ff;
  end

  // Idle high: a floating pin means 8-bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ind_meta_ff <= 1'b1;
      ind_sync_ff <= 1'b1;
    end else begin
      ind_meta_ff <= nxt_ind_meta;
      ind_sync_ff <= nxt_ind_sync;
    end
  end

  // ==========================================================
  // Window decode
  swen_if dif ();

  assign dif.mem_en    = win_enable_ff[`SWEN_EN_MEM_MSB:`SWEN_EN_MEM_LSB];
  assign dif.io_en     = {win_enable_ff[`SWEN_EN_IO1], win_enable_ff[`SWEN_EN_IO0]};
  assign dif.io_ctrl   = io_ctrl_ff;
  assign dif.acc_is_io = acc_is_io;
  assign dif.mem_hit   = acc_mem_hit;
  assign dif.io_hit    = acc_io_hit;
  assign dif.ind16     = ~ind_sync_ff;

  swen_window_decode swen_window_decode_inst (
    .d (dif.dec)
  );

  // ==========================================================
  // Card access sequencer
  swen_state_t state_ff;
  swen_state_t nxt_state;
  logic        start_ff;
  logic        nxt_start;
  logic [2:0]  win_id_ff;
  logic [2:0]  nxt_win_id;
  logic        is_io_ff;
  logic        nxt_is_io;
  logic        width16_ff;
  logic        nxt_width16;
  logic        tsel_ff;
  logic        nxt_tsel;
  logic        auto_ff;
  logic        nxt_auto;

  // Unclaimed requests are taken and dropped so the host never hangs
  assign acc_ready = (state_ff == SWEN_ST_IDLE);
  assign acc_claim = acc_valid & acc_ready & dif.claim;

  assign card_start     = start_ff;
  assign card_busy      = (state_ff == SWEN_ST_BUSY);
  assign card_win_id    = win_id_ff;
  assign card_is_io     = is_io_ff;
  assign card_width16   = width16_ff;
  assign card_timer_set = tsel_ff;

  always_comb begin
    nxt_state   = state_ff;
    nxt_start   = 1'b0;
    nxt_win_id  = win_id_ff;
    nxt_is_io   = is_io_ff;
    nxt_width16 = width16_ff;
    nxt_tsel    = tsel_ff;
    nxt_auto    = auto_ff;
    case (state_ff)
      SWEN_ST_IDLE: begin
        if (acc_claim) begin
          nxt_state   = SWEN_ST_BUSY;
          nxt_start   = 1'b1;
          nxt_win_id  = dif.win_id;
          nxt_is_io   = acc_is_io;
          nxt_width16 = dif.width16;
          nxt_tsel    = dif.timer_set;
          nxt_auto    = acc_is_io &
                        (dif.win_id[0] ? io_ctrl_ff[`SWEN_CTL_AUTO1] : io_ctrl_ff[`SWEN_CTL_AUTO0]);
        end
      end
      SWEN_ST_BUSY: begin
        // Auto-sized windows track the card during the whole access
        if (auto_ff) begin
          nxt_width16 = ~ind_sync_ff;
        end
        if (card_done) begin
          nxt_state = SWEN_ST_IDLE;
        end
      end
      default: begin
        nxt_state = SWEN_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= SWEN_ST_IDLE;
      start_ff   <= 1'b0;
      win_id_ff  <= 3'h0;
      is_io_ff   <= 1'b0;
      width16_ff <= 1'b0;
      tsel_ff    <= 1'b0;
      auto_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      start_ff   <= nxt_start;
      win_id_ff  <= nxt_win_id;
      is_io_ff   <= nxt_is_io;
      width16_ff <= nxt_width16;
      tsel_ff    <= nxt_tsel;
      auto_ff    <= nxt_auto;
    end
  end

endmodule : swen_top

// >>> dv/swen_checker.sv
// Port-level assertions for the socket window enable block.
// Assumes one clock domain and a bind onto swen_top.
`timescale 1ns/1ps
module swen_checker (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Register bus write side
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  // Host access
  input wire logic       acc_valid,
  input wire logic       acc_is_io,
  input wire logic [4:0] acc_mem_hit,
  input wire logic [1:0] acc_io_hit,
  input wire logic       acc_ready,
  input wire logic       acc_claim,
  // Card side
  input wire logic       card_done,
  input wire logic       card_start,
  input wire logic       card_busy,
  input wire logic [2:0] card_win_id,
  input wire logic       card_is_io,
  input wire logic       card_width16,
  input wire logic       card_timer_set
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Card access sequencing and register write response ordering
  AST_CLAIM_START: assert property (
    acc_claim |=> card_start && card_busy && card_is_io == $past(acc_is_io)) else $error("claim gave no start");
  AST_UNCLAIMED_IDLE: assert property (
    acc_valid && acc_ready && !acc_claim |=> !card_start && !card_busy) else $error("unclaimed access started");
  AST_CLAIM_HIT: assert property (
    acc_claim |-> acc_valid && (acc_is_io ? |acc_io_hit : |acc_mem_hit)) else $error("claim without hit");
  AST_START_PULSE: assert property (
    card_start |=> !card_start) else $error("start longer than one cycle");
  AST_BUSY_DONE: assert property (
    card_busy && card_done |=> !card_busy && acc_ready) else $error("busy not ended by done");
  AST_BUSY_HOLD: assert property (
    card_busy && !card_done |=> card_busy && $stable(card_win_id) && $stable(card_timer_set))
    else $error("access changed before done");
  AST_MEM_PATH: assert property (
    card_busy && !card_is_io |-> !card_width16 && !card_timer_set && card_win_id <= 3'h4)
    else $error("bad memory access fields");
  AST_IO_ID: assert property (
    card_busy && card_is_io |-> card_win_id <= 3'h1) else $error("bad I/O window index");
  AST_NO_TAKE_BUSY: assert property (
    card_busy |-> !acc_ready && !acc_claim) else $error("request taken while busy");
  AST_WRITE_ORDER: assert property (
    $rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready)) else $error("response before both taken");
endmodule : swen_checker

bind swen_top swen_checker swen_checker_inst (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .acc_valid, .acc_is_io, .acc_mem_hit, .acc_io_hit, .acc_ready, .acc_claim, .card_done, .card_start,
  .card_busy, .card_win_id, .card_is_io, .card_width16, .card_timer_set);

// >>> dv/swen_card_model.sv
// Behavioural PC card in the socket: width pin and access completion.
// Assumes the block pulses card_start and holds card_busy per access.
`timescale 1ns/1ps
module swen_card_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Access from the block
  input  wire logic       card_start,
  input  wire logic       card_busy,
  // Bench controls
  input  wire logic       wide,
  input  wire logic [3:0] wait_cycles,
  // Card pins
  output logic            card_io_width_indicator_n,
  output logic            card_done
);
  logic [3:0] cnt_ff;
  // Active low: card reports a 16-bit port
  assign card_io_width_indicator_n = ~wide;
  always_ff @(posedge aclk) begin
    if (!aresetn || card_start) begin
      cnt_ff <= 4'h0;
    end else if (card_busy) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
  // Done only inside an access, so a stray pulse cannot end the next one
  assign card_done = card_busy && !card_start && (cnt_ff >= wait_cycles);
endmodule : swen_card_model

// >>> dv/test_socket_window_enable_ctrl.sv
// Self-checking bench for the socket window enable block.
// Assumes swen_top, the card model and the checker are compiled first.
`timescale 1ns/1ps
`include "swen_consts.svh"
module test_socket_window_enable_ctrl;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, wait_cycles;
  logic [1:0]  s_axi_bresp, s_axi_rresp, acc_io_hit;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wide;
  logic        acc_valid, acc_is_io, acc_ready, acc_claim, card_io_width_indicator_n, card_done;
  logic        card_start, card_busy, card_is_io, card_width16, card_timer_set;
  logic [4:0]  acc_mem_hit;
  logic [2:0]  card_win_id;
  logic [7:0]  ctl [8] = '{8'h01, 8'h08, 8'h03, 8'h02, 8'h10, 8'h80, 8'h30, 8'h20};
  logic [7:0]  wmask = 8'hAA, w16m = 8'h99, tsm = 8'h22;
  int          num_errors, samples_checked, i;

  swen_top swen_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .acc_valid,
    .acc_is_io, .acc_mem_hit, .acc_io_hit, .acc_ready, .acc_claim, .card_io_width_indicator_n, .card_done,
    .card_start, .card_busy, .card_win_id, .card_is_io, .card_width16, .card_timer_set);
  swen_card_model swen_card_model_inst (.aclk, .aresetn, .card_start, .card_busy, .wide, .wait_cycles,
    .card_io_width_indicator_n, .card_done);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ==========
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic timed_out(input int n);
    if (n >= 100) begin
      check(32'h0, 32'h1);
      complete_run();
    end
  endtask : timed_out

  // Flags sampled 1 ns after an edge are settled until the next edge
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] exp);
    logic aw, w, b;
    int   n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      #1;
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      if (b) check(32'(s_axi_bresp), 32'(exp));
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    timed_out(n);
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    logic ar, r;
    int   n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      #1;
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid && s_axi_rready;
      if (r) begin
        check(s_axi_rdata, exp);
        check(32'(s_axi_rresp), 32'(exp_resp));
      end
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (r) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    timed_out(n);
  endtask : axi_read

  task automatic access(input logic io, input logic [4:0] mh, input logic [1:0] ih, input logic c,
                        input logic [4:0] f);
    int n;
    @(posedge aclk);
    acc_valid <= 1'b1;
    acc_is_io <= io;
    acc_mem_hit <= mh;
    acc_io_hit <= ih;
    #1;
    check(32'({acc_ready, acc_claim}), 32'({1'b1, c}));
    @(posedge aclk);
    acc_valid <= 1'b0;
    #1;
    check(32'({card_start, card_busy}), 32'({c, c}));
    if (c) check(32'({card_is_io, card_win_id, card_width16, card_timer_set}), 32'({io, f}));
    for (n = 0; n < 100 && card_busy; n++) begin
      @(posedge aclk);
      #1;
    end
    timed_out(n);
  endtask : access

  // ==========
  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {acc_valid, acc_is_io, wide, acc_mem_hit, acc_io_hit, wait_cycles} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`SWEN_ADDR_WIN_ENABLE, 32'h0, `SWEN_RESP_OKAY);
    axi_read(`SWEN_ADDR_IO_WIN_CTRL, 32'h0, `SWEN_RESP_OKAY);
    axi_write(32'h20, 32'hFF, `SWEN_RESP_SLVERR);
    axi_read(32'h20, 32'h0, `SWEN_RESP_SLVERR);
    axi_write(`SWEN_ADDR_WIN_ENABLE, 32'hFF, `SWEN_RESP_OKAY);
    axi_read(`SWEN_ADDR_WIN_ENABLE, 32'hDF, `SWEN_RESP_OKAY);
    // Byte 0 not strobed: write answered but register untouched
    s_axi_wstrb <= 4'hE;
    axi_write(`SWEN_ADDR_WIN_ENABLE, 32'h00, `SWEN_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_read(`SWEN_ADDR_WIN_ENABLE, 32'hDF, `SWEN_RESP_OKAY);
    // Overlapping hits: lowest enabled window wins
    for (i = 0; i < 5; i++) begin
      access(1'b0, 5'h1F << i, 2'h0, 1'b1, {3'(i), 2'h0});
    end
    for (i = 0; i < 5; i++) begin
      axi_write(`SWEN_ADDR_WIN_ENABLE, 32'hDF ^ (32'h1 << i), `SWEN_RESP_OKAY);
      access(1'b0, 5'h1 << i, 2'h0, 1'b0, 5'h0);
      access(1'b0, 5'h1F, 2'h0, 1'b1, {3'(i == 0), 2'h0});
    end
    // Hits come from outside comparators kept clear of the own base range
    axi_write(`SWEN_ADDR_WIN_ENABLE, 32'h80, `SWEN_RESP_OKAY);
    access(1'b1, 5'h1F, 2'h3, 1'b1, 5'h4);
    access(1'b0, 5'h1F, 2'h3, 1'b0, 5'h0);
    axi_write(`SWEN_ADDR_WIN_ENABLE, 32'h40, `SWEN_RESP_OKAY);
    access(1'b1, 5'h0, 2'h2, 1'b0, 5'h0);
    axi_write(`SWEN_ADDR_WIN_ENABLE, 32'hC0, `SWEN_RESP_OKAY);
    // Fixed and automatic sizing, timer sets, prompt and slow card
    for (i = 0; i < 8; i++) begin
      axi_write(`SWEN_ADDR_IO_WIN_CTRL, {24'h0, ctl[i]}, `SWEN_RESP_OKAY);
      axi_read(`SWEN_ADDR_IO_WIN_CTRL, {24'h0, ctl[i]}, `SWEN_RESP_OKAY);
      wide <= wmask[i];
      wait_cycles <= 4'(i);
      repeat (4) @(posedge aclk);
      access(1'b1, 5'h0, (i < 4) ? 2'h1 : 2'h2, 1'b1, {3'(i / 4), w16m[i], tsm[i]});
    end
    // Reset in mid-run brings both registers back to zero
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`SWEN_ADDR_WIN_ENABLE, 32'h0, `SWEN_RESP_OKAY);
    axi_read(`SWEN_ADDR_IO_WIN_CTRL, 32'h0, `SWEN_RESP_OKAY);
    access(1'b1, 5'h0, 2'h1, 1'b0, 5'h0);
    complete_run();
  end
endmodule : test_socket_window_enable_ctrl
